// File: rtl/wmr_regs.sv
// wake-up measurement register bank, Avalon-MM slave with waitrequest
// assumes byte addresses, one register per 32-bit word, data in bits 7:0
// assumes the measurement front ends pulse valid for one cycle per result
// Functional notes
// R01: bits 7:4 of the capacitance configuration hold the wake threshold on the difference.
// R02: bit 3 decides whether a measurement that raised the wake event joins the average.
// R03: bits 2:1 pick the average weight 4, 8, 16 or 32.
// R04: bit 0 picks the fixed capacitance reference or the running average for the compare.
// R05: the phase reference byte is read-write and resets to zero.
// R06: the running phase average reads back as a read-only byte, zero after reset.
// R07: the last phase result reads back as a read-only byte, zero after reset.
// R08: capacitance reference is read-write, average and last result read-only, all reset to zero.
// R09: the identity byte holds the type code in bits 7:3 and revision in 2:0 and ignores writes.
// R10: phase configuration bit 0 picks the fixed phase reference or the running phase average.
// R11: a capacitance result off its reference by more than the threshold raises the wake event.
// R12: the average moves by the difference of new result and old average divided by the weight.
`timescale 1ns/10ps
`default_nettype none
`include "wmr_defs.svh"
module wmr_regs
#(
  parameter logic [4:0] CHIP_TYPE = `WMR_CHIP_TYPE_DFLT,
  parameter logic [2:0] CHIP_REV = `WMR_CHIP_REV_DFLT
)
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [8:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output var logic [31:0] avs_readdata,
  output var logic avs_waitrequest,
  input wire logic phase_meas_valid,
  input wire logic [7:0] phase_meas_data,
  input wire logic cap_meas_valid,
  input wire logic [7:0] cap_meas_data,
  output var logic wake_irq
);
  localparam int NCH = 2;

  logic [6:0] idx;
  logic wait_q;
  logic wr_take;
  logic rd_start;
  logic [31:0] rdata_q;
  logic [7:0] rd_mux;
  wmr_pkg::wmr_cfg_s cfg_q [NCH];
  wmr_pkg::wmr_byte_t ref_q [NCH];
  logic [1:0] status_q;
  logic [1:0] status_d;
  logic [1:0] mask_q;
  logic irq_q;
  logic [NCH-1:0] ev;
  logic [NCH-1:0] meas_valid;
  wmr_pkg::wmr_byte_t meas_data [NCH];
  wmr_pkg::wmr_byte_t avg_v [NCH];
  wmr_pkg::wmr_byte_t last_v [NCH];
  logic [7:0] wbyte;
  logic wlane;

  assign idx = avs_address[8:2];
  assign wbyte = avs_writedata[7:0];
  assign wlane = avs_byteenable[0];
  assign wr_take = avs_write && !wait_q && wlane;
  assign rd_start = avs_read && wait_q;
  assign meas_valid = {cap_meas_valid, phase_meas_valid};
  assign meas_data[0] = phase_meas_data;
  assign meas_data[1] = cap_meas_data;

  // ==========================================
  // channels: 0 phase, 1 capacitance
  // both channels share one module; the phase one reads the same field layout
  wmr_chan_if chan_bus [NCH] ();

  generate
    for (genvar c = 0; c < NCH; c++)
    begin : g_chan
      assign chan_bus[c].cfg = cfg_q[c];
      assign chan_bus[c].fixed_ref = ref_q[c];
      assign chan_bus[c].meas_valid = meas_valid[c];
      assign chan_bus[c].meas_data = meas_data[c];
      assign avg_v[c] = chan_bus[c].avg;
      assign last_v[c] = chan_bus[c].last;
      assign ev[c] = chan_bus[c].event_p;
      wmr_chan u_chan
      (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .bus(chan_bus[c].chan)
      );
    end
  endgenerate

  // ==========================================
  // bus handshake: one wait cycle per access
  // fixed latency: read data comes from a flop, so no mux sits on the bus output path
  // a request held through the data phase is not taken twice, since wait_q rises again
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wait_q <= 1'b1;
    end
    else
    begin
      wait_q <= !((avs_read || avs_write) && wait_q);
    end
  end

  // ==========================================
  // writable registers
  // writes land only in the data phase, when the master has seen waitrequest low
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_q[0] <= `WMR_RST_BYTE;
      cfg_q[1] <= `WMR_RST_BYTE; // [R01] [R02] [R03] [R04]
      ref_q[0] <= `WMR_RST_BYTE; // [R05]
      ref_q[1] <= `WMR_RST_BYTE; // [R08]
      mask_q <= `WMR_RST_IRQ;
    end
    else if (wr_take)
    begin
      // identity, averages and last results have no write path
      unique case (idx) // [R09]
        `WMR_IDX_PHASE_CFG: cfg_q[0] <= wbyte; // [R10]
        `WMR_IDX_PHASE_REF: ref_q[0] <= wbyte; // [R05]
        `WMR_IDX_CAP_CFG: cfg_q[1] <= wbyte; // [R01] [R02] [R03] [R04]
        `WMR_IDX_CAP_REF: ref_q[1] <= wbyte; // [R08]
        `WMR_IDX_IRQ_MASK: mask_q <= wbyte[1:0];
        default: ;
      endcase
    end
  end

  // ==========================================
  // interrupt status, set wins over a write-one clear
  // losing a wake is worse than one spurious interrupt, hence set over clear
  // the level is taken from status_d so the interrupt rises with the status bit
  always_comb
  begin
    status_d = status_q;
    if (wr_take && idx == `WMR_IDX_IRQ_STATUS)
    begin
      status_d = status_d & ~wbyte[1:0];
    end
    status_d[`WMR_IRQ_PHASE_BIT] = status_d[`WMR_IRQ_PHASE_BIT] | ev[0];
    status_d[`WMR_IRQ_CAP_BIT] = status_d[`WMR_IRQ_CAP_BIT] | ev[1]; // [R11]
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      status_q <= `WMR_RST_IRQ;
    end
    else
    begin
      status_q <= status_d;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= |(status_d & mask_q);
    end
  end

  // ==========================================
  // read path; unmapped words read zero
  // the mux is captured at the first edge of the request
  always_comb
  begin
    unique case (idx)
      `WMR_IDX_PHASE_CFG: rd_mux = cfg_q[0];
      `WMR_IDX_PHASE_REF: rd_mux = ref_q[0]; // [R05]
      `WMR_IDX_PHASE_AVG: rd_mux = avg_v[0]; // [R06]
      `WMR_IDX_PHASE_LAST: rd_mux = last_v[0]; // [R07]
      `WMR_IDX_CAP_CFG: rd_mux = cfg_q[1];
      `WMR_IDX_CAP_REF: rd_mux = ref_q[1]; // [R08]
      `WMR_IDX_CAP_AVG: rd_mux = avg_v[1]; // [R08]
      `WMR_IDX_CAP_LAST: rd_mux = last_v[1]; // [R08]
      `WMR_IDX_IDENT: rd_mux = {CHIP_TYPE, CHIP_REV}; // [R09]
      `WMR_IDX_IRQ_STATUS: rd_mux = {6'h00, status_q};
      `WMR_IDX_IRQ_MASK: rd_mux = {6'h00, mask_q};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rdata_q <= 32'h0000_0000;
    end
    else if (rd_start)
    begin
      rdata_q <= {24'h00_0000, rd_mux};
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign wake_irq = irq_q;

  // ==========================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence s_req_first;
    (avs_read || avs_write) && wait_q;
  endsequence

  sequence s_done;
    !wait_q;
  endsequence

  sequence s_read_first;
    avs_read && wait_q;
  endsequence

  sequence s_write_done;
    avs_write && !wait_q;
  endsequence

  a_wait_one_cycle: assert property (s_req_first |=> s_done ##1 wait_q)
    else $error("waitrequest not low for exactly one cycle");
  a_wait_idle: assert property (!(avs_read || avs_write) && wait_q |=> wait_q)
    else $error("waitrequest dropped without a request");
  a_rdata_hold: assert property (!(avs_read && wait_q) |=> $stable(avs_readdata))
    else $error("read data changed outside a read");
  a_ident_read: assert property (s_read_first ##0 (idx == `WMR_IDX_IDENT)
    |=> avs_readdata == {24'h00_0000, CHIP_TYPE, CHIP_REV}) // [R09]
    else $error("identity byte wrong");

  // writes
  a_cap_cfg_write: assert property (wr_take && idx == `WMR_IDX_CAP_CFG
    |=> 8'(cfg_q[1]) == $past(wbyte)) // [R01]
    else $error("capacitance configuration not stored");
  a_phase_ref_write: assert property (wr_take && idx == `WMR_IDX_PHASE_REF
    |=> ref_q[0] == $past(wbyte)) // [R05]
    else $error("phase reference not stored");
  a_cap_ref_write: assert property (wr_take && idx == `WMR_IDX_CAP_REF
    |=> ref_q[1] == $past(wbyte)) // [R08]
    else $error("capacitance reference not stored");
  a_phase_cfg_write: assert property (wr_take && idx == `WMR_IDX_PHASE_CFG
    |=> 8'(cfg_q[0]) == $past(wbyte)) // [R10]
    else $error("phase configuration not stored");
  a_mask_write: assert property (wr_take && idx == `WMR_IDX_IRQ_MASK
    |=> mask_q == $past(wbyte[1:0]))
    else $error("interrupt mask not stored");
  a_lane_refused: assert property (s_write_done ##0 !wlane
    |=> $stable(ref_q[0]) && $stable(ref_q[1]) && $stable(mask_q)) // [R05]
    else $error("write without byte lane 0 took effect");

  // read views
  a_phase_avg_read: assert property (s_read_first ##0 (idx == `WMR_IDX_PHASE_AVG)
    |=> avs_readdata[7:0] == $past(avg_v[0])) // [R06]
    else $error("phase average view wrong");
  a_phase_ref_read: assert property (s_read_first ##0 (idx == `WMR_IDX_PHASE_REF)
    |=> avs_readdata[7:0] == $past(ref_q[0])) // [R05]
    else $error("phase reference read wrong");
  a_phase_last_read: assert property (s_read_first ##0 (idx == `WMR_IDX_PHASE_LAST)
    |=> avs_readdata[7:0] == $past(last_v[0])) // [R07]
    else $error("phase result view wrong");
  a_cap_avg_read: assert property (s_read_first ##0 (idx == `WMR_IDX_CAP_AVG)
    |=> avs_readdata[7:0] == $past(avg_v[1])) // [R08]
    else $error("capacitance average view wrong");
  a_cap_last_read: assert property (s_read_first ##0 (idx == `WMR_IDX_CAP_LAST)
    |=> avs_readdata[7:0] == $past(last_v[1])) // [R08]
    else $error("capacitance result view wrong");
  a_unmapped_read: assert property (s_read_first
    ##0 (idx < `WMR_IDX_PHASE_CFG || idx > `WMR_IDX_IRQ_MASK) |=> avs_readdata == 32'h0000_0000)
    else $error("unmapped word did not read zero");

  // interrupt
  a_cap_event_sticky: assert property (ev[1] |=> status_q[`WMR_IRQ_CAP_BIT]) // [R11]
    else $error("capacitance wake event lost");
  a_phase_event_sticky: assert property (ev[0] |=> status_q[`WMR_IRQ_PHASE_BIT]) // [R10]
    else $error("phase wake event lost");
  a_status_clear: assert property (wr_take && idx == `WMR_IDX_IRQ_STATUS && ev == 2'h0
    |=> (status_q & $past(wbyte[1:0])) == 2'h0) // [R11]
    else $error("write-one clear of status failed");
  a_status_kept: assert property (!(wr_take && idx == `WMR_IDX_IRQ_STATUS)
    |=> (status_q & $past(status_q)) == $past(status_q)) // [R11]
    else $error("status bit cleared without a write");
  a_cap_event_irq: assert property (ev[1] && mask_q[1] |=> wake_irq) // [R11]
    else $error("unmasked capacitance event raised no interrupt");
  a_irq_quiet: assert property (status_q == 2'h0 && ev == 2'h0 |=> !wake_irq)
    else $error("interrupt raised with no status bit");
  a_irq_level: assert property (##1 wake_irq == |($past(status_d) & $past(mask_q)))
    else $error("interrupt level wrong");
endmodule // wmr_regs
`default_nettype wire

// File: rtl/wmr_defs.svh
// wake-up measurement register bank: offsets, field positions, reset values
// assumes a 32-bit word-per-register bus; byte address = index * 4
`ifndef WMR_DEFS_SVH
`define WMR_DEFS_SVH

// ==========================================
// register indices (byte address is index * 4)
`define WMR_IDX_PHASE_CFG 7'h37
`define WMR_IDX_PHASE_REF 7'h38
`define WMR_IDX_PHASE_AVG 7'h39
`define WMR_IDX_PHASE_LAST 7'h3A
`define WMR_IDX_CAP_CFG 7'h3B
`define WMR_IDX_CAP_REF 7'h3C
`define WMR_IDX_CAP_AVG 7'h3D
`define WMR_IDX_CAP_LAST 7'h3E
`define WMR_IDX_IDENT 7'h3F
`define WMR_IDX_IRQ_STATUS 7'h40
`define WMR_IDX_IRQ_MASK 7'h41

// ==========================================
// configuration byte fields
`define WMR_CFG_THR_MSB 7
`define WMR_CFG_THR_LSB 4
`define WMR_CFG_INCLUDE_BIT 3
`define WMR_CFG_WEIGHT_MSB 2
`define WMR_CFG_WEIGHT_LSB 1
`define WMR_CFG_USE_AVG_BIT 0

// ==========================================
// interrupt status bits and reset values
`define WMR_IRQ_PHASE_BIT 0
`define WMR_IRQ_CAP_BIT 1
`define WMR_RST_BYTE 8'h00
`define WMR_RST_IRQ 2'h0

// ==========================================
// weight shift: code 0..3 gives divide by 4,8,16,32
`define WMR_WEIGHT_BASE_SHIFT 4'h2

// identity defaults, arbitrary values
`define WMR_CHIP_TYPE_DFLT 5'h11
`define WMR_CHIP_REV_DFLT 3'h1

`endif

// File: rtl/wmr_pkg.sv
// wake-up measurement register bank: shared types
// assumes wmr_defs.svh for the numbers
package wmr_pkg;
  typedef logic [7:0] wmr_byte_t;
  typedef struct packed
  {
    logic [3:0] cap_delta_threshold;
    logic cap_include_trigger_sample;
    logic [1:0] cap_average_weight;
    logic cap_use_average_reference;
  } wmr_cfg_s;
endpackage

// File: rtl/wmr_chan_if.sv
// carrier between the register bank and one measurement channel
// assumes one instance per channel, all on sys_clk
`timescale 1ns/10ps
`default_nettype none
interface wmr_chan_if;
  wmr_pkg::wmr_cfg_s cfg;
  wmr_pkg::wmr_byte_t fixed_ref;
  logic meas_valid;
  wmr_pkg::wmr_byte_t meas_data;
  wmr_pkg::wmr_byte_t avg;
  wmr_pkg::wmr_byte_t last;
  logic event_p;
  modport bank (output cfg, output fixed_ref, output meas_valid, output meas_data,
    input avg, input last, input event_p);
  modport chan (input cfg, input fixed_ref, input meas_valid, input meas_data,
    output avg, output last, output event_p);
endinterface
`default_nettype wire

// File: rtl/wmr_chan.sv
// one measurement channel: last result, running average, wake compare
// assumes meas_valid is a one-cycle pulse per finished measurement
`timescale 1ns/10ps
`default_nettype none
`include "wmr_defs.svh"
module wmr_chan
(
  input wire logic sys_clk,
  input wire logic reset_n,
  wmr_chan_if.chan bus
);
  logic [7:0] avg_q;
  logic [7:0] last_q;
  logic event_q;
  logic [7:0] ref_sel;
  logic signed [8:0] ref_diff;
  logic [8:0] ref_mag;
  logic exceed;
  logic signed [8:0] avg_diff;
  logic signed [8:0] avg_step;
  logic [3:0] shift;
  logic [8:0] avg_sum;

  // ==========================================
  // compare
  always_comb
  begin
    ref_sel = bus.cfg.cap_use_average_reference ? avg_q : bus.fixed_ref; // [R04] [R10]
    ref_diff = $signed({1'b0, bus.meas_data}) - $signed({1'b0, ref_sel});
    ref_mag = ref_diff[8] ? 9'(-ref_diff) : ref_diff;
    exceed = ref_mag > {5'h00, bus.cfg.cap_delta_threshold}; // [R01] [R11]
    shift = `WMR_WEIGHT_BASE_SHIFT + {2'h0, bus.cfg.cap_average_weight}; // [R03]
    avg_diff = $signed({1'b0, bus.meas_data}) - $signed({1'b0, avg_q});
    avg_step = avg_diff >>> shift; // [R12]
    avg_sum = 9'($signed({1'b0, avg_q}) + avg_step);
  end

  // ==========================================
  // state
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      last_q <= `WMR_RST_BYTE;
    end
    else if (bus.meas_valid)
    begin
      last_q <= bus.meas_data; // [R07]
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      avg_q <= `WMR_RST_BYTE;
    end
    else if (bus.meas_valid && (!exceed || bus.cfg.cap_include_trigger_sample)) // [R02]
    begin
      avg_q <= avg_sum[7:0]; // [R12]
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      event_q <= 1'b0;
    end
    else
    begin
      event_q <= bus.meas_valid && exceed; // [R11]
    end
  end

  assign bus.avg = avg_q;
  assign bus.last = last_q;
  assign bus.event_p = event_q;

  // ==========================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_last_capture: assert property (bus.meas_valid |=> last_q == $past(bus.meas_data)) // [R07]
    else $error("last result not captured");
  a_event_thresh: assert property (bus.meas_valid && exceed
    |=> event_q ##1 (!event_q || $past(bus.meas_valid && exceed))) // [R11]
    else $error("wake event missing");
  a_avg_excluded: assert property (bus.meas_valid && exceed && !bus.cfg.cap_include_trigger_sample
    |=> $stable(avg_q)) // [R02]
    else $error("triggering sample entered average");
  a_weight_four: assert property (bus.meas_valid && !exceed && bus.cfg.cap_average_weight == 2'h0
    |=> $signed({1'b0, avg_q}) == $signed({1'b0, $past(avg_q)}) + ($past(avg_diff) >>> 2)) // [R03]
    else $error("average step wrong for weight 4");
  a_ref_source: assert property (bus.meas_valid && !bus.cfg.cap_use_average_reference
    && bus.meas_data == bus.fixed_ref |=> !event_q) // [R04]
    else $error("wrong reference source");
endmodule // wmr_chan
`default_nettype wire

// File: tb/wmr_meas_src.sv
// far-side model: the phase and capacitance front ends feeding wmr_regs
// assumes one sys_clk; the bench calls send() for each finished measurement
`timescale 1ns/10ps
`default_nettype none
module wmr_meas_src
(
  input wire logic sys_clk,
  output logic phase_meas_valid,
  output logic [7:0] phase_meas_data,
  output logic cap_meas_valid,
  output logic [7:0] cap_meas_data
);
  initial
  begin
    phase_meas_valid = 1'b0;
    cap_meas_valid = 1'b0;
    phase_meas_data = 8'h5A;
    cap_meas_data = 8'hA5;
  end

  // one-cycle pulse; data inverted after so a stale value is never read as good
  task automatic send(input logic ch, input logic [7:0] d);
    @(posedge sys_clk);
    phase_meas_valid <= ~ch;
    cap_meas_valid <= ch;
    phase_meas_data <= d;
    cap_meas_data <= d;
    @(posedge sys_clk);
    phase_meas_valid <= 1'b0;
    cap_meas_valid <= 1'b0;
    phase_meas_data <= ~d;
    cap_meas_data <= ~d;
  endtask
endmodule // wmr_meas_src
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench for wmr_regs over Avalon-MM
// assumes wmr_defs.svh on the include path and the wmr_meas_src model
`timescale 1ns/10ps
`default_nettype none
`include "wmr_defs.svh"
module tb_top;
  logic sys_clk, reset_n, avs_read, avs_write, avs_waitrequest, wake_irq;
  logic [8:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic phase_meas_valid, cap_meas_valid;
  logic [7:0] phase_meas_data, cap_meas_data, q, e_st, e_mask;
  logic [7:0] e_avg [2];
  logic [7:0] e_last [2];
  int err_count, comparisons;

  wmr_regs u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .phase_meas_valid(phase_meas_valid),
    .phase_meas_data(phase_meas_data), .cap_meas_valid(cap_meas_valid),
    .cap_meas_data(cap_meas_data), .wake_irq(wake_irq));
  wmr_meas_src u_src (.sys_clk(sys_clk), .phase_meas_valid(phase_meas_valid),
    .phase_meas_data(phase_meas_data), .cap_meas_valid(cap_meas_valid),
    .cap_meas_data(cap_meas_data));

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ==========================================
  // checking and bus helpers
  task automatic print_verdict();
    $display("comparisons=%0d mismatches=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // request held until waitrequest is sampled low at a rising edge; data taken at that edge
  task automatic bus(input logic w, input logic [8:0] a, input logic [7:0] d,
    input logic [3:0] be);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_read <= ~w;
    avs_write <= w;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0 && n < 50)
    begin
      n++;
      @(posedge sys_clk);
    end
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0)
    begin
      err_count++;
      print_verdict();
    end
  endtask

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask

  task automatic rd_chk(input logic [8:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00, 4'hF);
    chk(q, exp);
  endtask

  task automatic irq_chk();
    repeat (2) @(posedge sys_clk);
    chk({7'h0, wake_irq}, {7'h0, |(e_st & e_mask)});
  endtask

  function automatic logic [7:0] avg_nx(logic [7:0] a, logic [7:0] n, logic [1:0] w);
    logic signed [8:0] d;
    d = $signed({1'b0, n}) - $signed({1'b0, a});
    return a + 8'(d >>> (2 + w));
  endfunction

  // one measurement on channel ch (0 phase, 1 capacitance) with a fresh setup
  task automatic meas(input logic ch, input logic [7:0] cfg, input logic [7:0] rf,
    input logic [7:0] d);
    logic [8:0] b;
    logic [7:0] r;
    logic hit;
    b = ch ? 9'h0EC : 9'h0DC;
    wr(b, cfg);
    wr(b + 9'h004, rf);
    r = cfg[0] ? e_avg[ch] : rf;
    hit = ((d > r) ? d - r : r - d) > {4'h0, cfg[7:4]};
    if (!hit || cfg[3])
      e_avg[ch] = avg_nx(e_avg[ch], d, cfg[2:1]);
    e_last[ch] = d;
    e_st[ch] = e_st[ch] | hit;
    u_src.send(ch, d);
    repeat (4) @(posedge sys_clk);
    rd_chk(b + 9'h008, e_avg[ch]);
    rd_chk(b + 9'h00C, e_last[ch]);
    rd_chk(9'h100, e_st);
    irq_chk();
  endtask

  // ==========================================
  // tests
  initial
  begin
    reset_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 9'h000;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    err_count = 0;
    comparisons = 0;
    e_avg = '{8'h00, 8'h00};
    e_last = '{8'h00, 8'h00};
    e_st = 8'h00;
    e_mask = 8'h00;
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    for (int a = 'hDC; a <= 'h108; a += 4)
      rd_chk(9'(a), (a == 'hFC) ? {`WMR_CHIP_TYPE_DFLT, `WMR_CHIP_REV_DFLT} : 8'h00);
    $display("test reset_values done");

    // read-only, identity and unmapped words must ignore writes
    for (int a = 'hDC; a <= 'hFC; a += 4)
      wr(9'(a), 8'hA5);
    wr(9'h108, 8'hA5);
    bus(1'b1, 9'h0E0, 8'h3C, 4'hE);
    for (int a = 'hDC; a <= 'h108; a += 4)
      rd_chk(9'(a), (a == 'hFC) ? {`WMR_CHIP_TYPE_DFLT, `WMR_CHIP_REV_DFLT} :
        (a == 'hDC || a == 'hE0 || a == 'hEC || a == 'hF0) ? 8'hA5 : 8'h00);
    $display("test access_kinds done");

    wr(9'h104, 8'h02);
    e_mask = 8'h02;
    meas(1'b1, 8'h40, 8'h40, 8'h44);
    meas(1'b1, 8'h40, 8'h40, 8'h45);
    wr(9'h100, 8'h02);
    e_st[1] = 1'b0;
    irq_chk();
    meas(1'b1, 8'h48, 8'h40, 8'h3B);
    meas(1'b1, 8'h02, 8'h40, 8'h40);
    meas(1'b1, 8'h0C, 8'h40, 8'h00);
    meas(1'b1, 8'h0E, 8'h40, 8'hC0);
    meas(1'b1, 8'hF0, 8'hFF, 8'hFF);
    meas(1'b1, 8'hF1, 8'hFF, 8'hFF);
    meas(1'b0, 8'h08, 8'h10, 8'h11);
    meas(1'b0, 8'hF1, 8'h00, 8'h80);
    $display("test measurements done");

    wr(9'h104, 8'h01);
    e_mask = 8'h01;
    irq_chk();
    wr(9'h104, 8'h00);
    e_mask = 8'h00;
    irq_chk();
    wr(9'h100, 8'h03);
    e_st = 8'h00;
    rd_chk(9'h100, 8'h00);
    $display("test interrupt_mask done");
    print_verdict();
  end

  initial
  begin
    #(25 * 20000);
    err_count++;
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
